// ==== rtl/motion_output_data_regs.sv ====
`timescale 1ns/10ps

// Summary of operation
// RL1 - Gyro X rate at 22h low, 23h high
// RL2 - Gyro Y rate at 24h low, 25h high
// RL3 - Gyro Z rate at 26h low, 27h high
// RL4 - Accel X at 28h low, 29h high
// RL5 - Accel Y at 2Ah low, 2Bh high
// RL6 - Accel Z at 2Ch low, 2Dh high
// RL7 - Primary port reads general-purpose gyro chain data
// RL8 - Auxiliary port reads stabilization gyro chain data
// RL9 - Primary port reads general-purpose accel chain data
// RL10 - Auxiliary port reads stabilization accel chain data
// RL11 - Status bit 7 flags long-counter timeout
// RL12 - Status bit flags significant motion event
// RL13 - Status bit flags tilt event
// RL14 - Status bit flags step event
// RL15 - Auxiliary high-byte read clears data-available flags
// RL16 - Status layout bits 7,5,4,3; rest zero
// RL17 - Writes to these registers are ignored
module motion_output_data_regs
   import motion_regs_pkg::*;
(
   input  wire logic      clock_i,
   input  wire logic      resetn_i,
   input  wire six_axis_t gen_sample_i,
   input  wire logic      gen_gyro_strobe_i,
   input  wire logic      gen_accel_strobe_i,
   input  wire six_axis_t stab_sample_i,
   input  wire logic      stab_gyro_strobe_i,
   input  wire logic      stab_accel_strobe_i,
   input  wire event_t    events_i,
   input  wire reg_req_t  primary_req_i,
   output reg_rsp_t       primary_rsp_o,
   input  wire reg_req_t  aux_req_i,
   output reg_rsp_t       aux_rsp_o,
   output logic           gyro_data_available_o,
   output logic           accel_data_available_o
);

   six_axis_t gen_q;
   six_axis_t stab_q;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic       gyro_da_q;
   logic       gyro_da_d;
   logic       accel_da_q;
   logic       accel_da_d;
   reg_rsp_t   primary_rsp_q;
   reg_rsp_t   primary_rsp_d;
   reg_rsp_t   aux_rsp_q;
   reg_rsp_t   aux_rsp_d;

   // True when the address falls inside the twelve output data bytes.
   function automatic logic in_output_range(input logic [7:0] addr);
      in_output_range = (addr >= ADDR_GYRO_X_LOW) && (addr <= ADDR_ACCEL_Z_HIGH);
   endfunction

   // Axis word index, 0..5, of an address inside the output range.
   function automatic logic [2:0] axis_index(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - ADDR_GYRO_X_LOW;
      axis_index = rel[3:1];
   endfunction

   // One read byte for a port; the sample set passed in selects the chain.
   function automatic logic [7:0] read_byte(input logic [7:0] addr,
                                             input six_axis_t  sample,
                                             input logic [7:0] status);
      logic [15:0] word;
      word = SAMPLE_RESET;
      read_byte = UNMAPPED_READ_VALUE;
      if (in_output_range(addr)) begin
         word = sample.word[axis_index(addr)];
         // Odd offsets are the high bytes, even ones the low bytes.
         read_byte = addr[0] ? word[15:8] : word[7:0]; // RL1 RL2 RL3 RL4 RL5 RL6
      end else if (addr == ADDR_EMBEDDED_EVENT_STATUS) begin
         read_byte = status;
      end
   endfunction

   // Each axis captures a whole 16-bit word at once; nothing holds the high byte, so a strobe between
   // the low-byte and high-byte reads gives a low byte of one sample and a high byte of another.
   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++) begin : gen_axis
         logic [AXIS_WIDTH-1:0] gen_d;
         logic [AXIS_WIDTH-1:0] stab_d;
         logic                  gen_load;
         logic                  stab_load;

         always_comb begin
            gen_load  = (g < NUM_GYRO_AXES) ? gen_gyro_strobe_i : gen_accel_strobe_i;
            stab_load = (g < NUM_GYRO_AXES) ? stab_gyro_strobe_i : stab_accel_strobe_i;
            gen_d  = gen_load ? gen_sample_i.word[g] : gen_q.word[g];     // RL7 RL9
            stab_d = stab_load ? stab_sample_i.word[g] : stab_q.word[g];  // RL8 RL10
         end

         always_ff @(posedge clock_i) begin
            if (!resetn_i) begin
               gen_q.word[g]  <= SAMPLE_RESET;
               stab_q.word[g] <= SAMPLE_RESET;
            end else begin
               gen_q.word[g]  <= gen_d;
               stab_q.word[g] <= stab_d;
            end
         end
      end
   endgenerate

   // Event status: a primary-port read of the register clears it, and an
   // event in the same cycle wins so that no event is lost.
   always_comb begin
      status_d = status_q;
      if (primary_req_i.rd && (primary_req_i.addr == ADDR_EMBEDDED_EVENT_STATUS)) begin
         status_d = STATUS_RESET;
      end
      if (events_i.long_counter_timeout_flag) begin
         status_d[POS_LONG_COUNTER_TIMEOUT] = 1'b1; // RL11 RL16
      end
      if (events_i.significant_motion_flag) begin
         status_d[POS_SIGNIFICANT_MOTION] = 1'b1; // RL12 RL16
      end
      if (events_i.tilt_event_flag) begin
         status_d[POS_TILT_EVENT] = 1'b1; // RL13 RL16
      end
      if (events_i.step_event_flag) begin
         status_d[POS_STEP_EVENT] = 1'b1; // RL14 RL16
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // Data-available flags seen by the auxiliary host; a new stabilization
   // sample in the clearing cycle keeps the flag set.
   always_comb begin
      logic aux_high;
      aux_high   = aux_req_i.rd && in_output_range(aux_req_i.addr) && aux_req_i.addr[0];
      gyro_da_d  = gyro_da_q;
      accel_da_d = accel_da_q;
      if (aux_high && (aux_req_i.addr <= ADDR_GYRO_Z_HIGH)) begin
         gyro_da_d = 1'b0; // RL15
      end
      if (aux_high && (aux_req_i.addr >= ADDR_ACCEL_X_LOW)) begin
         accel_da_d = 1'b0; // RL15
      end
      if (stab_gyro_strobe_i) begin
         gyro_da_d = 1'b1;
      end
      if (stab_accel_strobe_i) begin
         accel_da_d = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         gyro_da_q  <= 1'b0;
         accel_da_q <= 1'b0;
      end else begin
         gyro_da_q  <= gyro_da_d;
         accel_da_q <= accel_da_d;
      end
   end

   // Read answers, one cycle after the strobe. The write strobe and data are
   // never looked at, since every register in this bank is read-only.
   always_comb begin
      primary_rsp_d.valid = primary_req_i.rd; // RL17
      primary_rsp_d.data  = primary_rsp_q.data;
      if (primary_req_i.rd) begin
         primary_rsp_d.data = read_byte(primary_req_i.addr, gen_q, status_q); // RL7 RL9
      end
      aux_rsp_d.valid = aux_req_i.rd; // RL17
      aux_rsp_d.data  = aux_rsp_q.data;
      if (aux_req_i.rd) begin
         aux_rsp_d.data = read_byte(aux_req_i.addr, stab_q, status_q); // RL8 RL10
      end
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         primary_rsp_q <= '0;
         aux_rsp_q     <= '0;
      end else begin
         primary_rsp_q <= primary_rsp_d;
         aux_rsp_q     <= aux_rsp_d;
      end
   end

   assign primary_rsp_o          = primary_rsp_q;
   assign aux_rsp_o              = aux_rsp_q;
   assign gyro_data_available_o  = gyro_da_q;
   assign accel_data_available_o = accel_da_q;

endmodule

// ==== rtl/motion_regs_pkg.sv ====
package motion_regs_pkg;

   // Register offsets as seen by both serial ports.
   localparam logic [7:0] ADDR_GYRO_X_LOW             = 8'h22;
   localparam logic [7:0] ADDR_GYRO_X_HIGH            = 8'h23;
   localparam logic [7:0] ADDR_GYRO_Y_LOW             = 8'h24;
   localparam logic [7:0] ADDR_GYRO_Y_HIGH            = 8'h25;
   localparam logic [7:0] ADDR_GYRO_Z_LOW             = 8'h26;
   localparam logic [7:0] ADDR_GYRO_Z_HIGH            = 8'h27;
   localparam logic [7:0] ADDR_ACCEL_X_LOW            = 8'h28;
   localparam logic [7:0] ADDR_ACCEL_X_HIGH           = 8'h29;
   localparam logic [7:0] ADDR_ACCEL_Y_LOW            = 8'h2A;
   localparam logic [7:0] ADDR_ACCEL_Y_HIGH           = 8'h2B;
   localparam logic [7:0] ADDR_ACCEL_Z_LOW            = 8'h2C;
   localparam logic [7:0] ADDR_ACCEL_Z_HIGH           = 8'h2D;
   localparam logic [7:0] ADDR_EMBEDDED_EVENT_STATUS  = 8'h35;

   // Field positions inside the embedded event status register.
   localparam int unsigned POS_LONG_COUNTER_TIMEOUT   = 7;
   localparam int unsigned POS_SIGNIFICANT_MOTION     = 5;
   localparam int unsigned POS_TILT_EVENT             = 4;
   localparam int unsigned POS_STEP_EVENT             = 3;

   // Axis layout: words 0..2 are gyro X/Y/Z, words 3..5 accel X/Y/Z.
   localparam int unsigned NUM_AXES                   = 6;
   localparam int unsigned NUM_GYRO_AXES              = 3;
   localparam int unsigned AXIS_WIDTH                 = 16;

   localparam logic [15:0] SAMPLE_RESET               = 16'h0000;
   localparam logic [7:0]  STATUS_RESET               = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ_VALUE        = 8'h00;

   typedef struct packed {
      logic [NUM_AXES-1:0][AXIS_WIDTH-1:0] word;
   } six_axis_t;

   typedef struct packed {
      logic long_counter_timeout_flag;
      logic significant_motion_flag;
      logic tilt_event_flag;
      logic step_event_flag;
   } event_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } reg_rsp_t;

endpackage

// ==== test/serial_host.sv ====
`timescale 1ns/10ps
module serial_host
   import motion_regs_pkg::*;
(
   input  wire logic     clock_i,
   input  wire reg_rsp_t rsp_i,
   output reg_req_t      req_o
);
   initial req_o = '0;
   // Call at a falling edge; a released address shows its inverse so stale decode shows up.
   task automatic xfer(input logic w, input logic [7:0] a, output logic [8:0] r);
      req_o = {~w, w, a, 8'hFF};
      @(negedge clock_i);
      r = rsp_i;
      req_o = {2'b00, ~a, 8'h00};
      @(negedge clock_i);
   endtask
endmodule

// ==== test/motion_output_data_regs_assertions.sv ====
`timescale 1ns/10ps
module motion_output_data_regs_assertions
   import motion_regs_pkg::*;
(
   input wire logic      clock_i,
   input wire logic      resetn_i,
   input wire six_axis_t gen_sample_i,
   input wire logic      gen_gyro_strobe_i,
   input wire logic      gen_accel_strobe_i,
   input wire six_axis_t stab_sample_i,
   input wire logic      stab_gyro_strobe_i,
   input wire logic      stab_accel_strobe_i,
   input wire event_t    events_i,
   input wire reg_req_t  primary_req_i,
   input wire reg_rsp_t  primary_rsp_o,
   input wire reg_req_t  aux_req_i,
   input wire reg_rsp_t  aux_rsp_o,
   input wire logic      gyro_data_available_o,
   input wire logic      accel_data_available_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   AST_PRI_LATENCY: assert property (primary_req_i.rd |=> primary_rsp_o.valid)
      else $error("primary read unanswered");
   AST_PRI_IDLE: assert property (!primary_req_i.rd |=> !primary_rsp_o.valid)
      else $error("primary answer without read");
   AST_AUX_LATENCY: assert property (aux_req_i.rd |=> aux_rsp_o.valid)
      else $error("aux read unanswered");
   AST_AUX_GYRO: assert property ($fell(stab_gyro_strobe_i) && aux_req_i.rd
      && aux_req_i.addr == 8'h23 |=> aux_rsp_o.data == $past(stab_sample_i.word[0][15:8], 2))
      else $error("aux gyro x high wrong");
   AST_PRI_ACCEL: assert property ($fell(gen_accel_strobe_i) && primary_req_i.rd
      && primary_req_i.addr == 8'h2C |=> primary_rsp_o.data == $past(gen_sample_i.word[5][7:0], 2))
      else $error("primary accel z low wrong");
   AST_GDA_CLEAR: assert property (aux_req_i.rd && aux_req_i.addr == 8'h23
      && !stab_gyro_strobe_i |=> !gyro_data_available_o) else $error("gyro flag kept");
   AST_XDA_CLEAR: assert property (aux_req_i.rd && aux_req_i.addr == 8'h2D
      && !stab_accel_strobe_i |=> !accel_data_available_o) else $error("accel flag kept");
   AST_STATUS_SPARE: assert property (primary_req_i.rd && primary_req_i.addr == 8'h35
      |=> primary_rsp_o.data[6] == 1'b0 && primary_rsp_o.data[2:0] == 3'h0)
      else $error("status spare bit set");
endmodule
bind motion_output_data_regs motion_output_data_regs_assertions u_chk (.*);

// ==== test/tb_motion_output_data_regs.sv ====
`timescale 1ns/10ps
module tb_motion_output_data_regs;
   import motion_regs_pkg::*;
   logic      clock_i = 0, resetn_i = 0, gen_gyro_strobe_i = 0, gen_accel_strobe_i = 0;
   logic      stab_gyro_strobe_i = 0, stab_accel_strobe_i = 0;
   six_axis_t gen_sample_i = '0, stab_sample_i = '0;
   event_t    events_i = '0;
   reg_req_t  primary_req_i, aux_req_i;
   reg_rsp_t  primary_rsp_o, aux_rsp_o;
   logic      gyro_data_available_o, accel_data_available_o;
   logic [8:0] r, r2;
   int        errors = 0, cmp_count = 0;
   motion_output_data_regs uut (.*);
   serial_host host_p (.clock_i(clock_i), .rsp_i(primary_rsp_o), .req_o(primary_req_i));
   serial_host host_a (.clock_i(clock_i), .rsp_i(aux_rsp_o), .req_o(aux_req_i));
   initial forever #12.5 clock_i = ~clock_i;
   function automatic logic [15:0] w(input int k, input logic o);
      return 16'hA0C3 ^ (16'(k) * 16'h1111) ^ (o ? 16'hFFFF : 16'h0000);
   endfunction
   // Expected answer of a read at offset 22h+i: valid plus the addressed byte.
   function automatic logic [8:0] ex(input int i, input logic o);
      logic [15:0] v;
      v = w(i / 2, o);
      return {1'b1, i[0] ? v[15:8] : v[7:0]};
   endfunction
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic strobe(input logic [3:0] s);
      {gen_gyro_strobe_i, gen_accel_strobe_i, stab_gyro_strobe_i, stab_accel_strobe_i} = s;
      @(negedge clock_i);
   endtask
   task automatic t_axes;
      host_p.xfer(0, 8'h23, r);
      chk(r, {1'b1, SAMPLE_RESET[15:8]});
      for (int k = 0; k < 6; k++) begin
         gen_sample_i.word[k] = w(k, 0);
         stab_sample_i.word[k] = w(k, 1);
      end
      strobe(4'hF);
      strobe(4'h0);
      for (int i = 0; i < 12; i++) begin
         host_p.xfer(0, 8'h22 + 8'(i), r);
         chk(r, ex(i, 0));
         host_a.xfer(0, 8'h22 + 8'(i), r);
         chk(r, ex(i, 1));
      end
   endtask
   task automatic t_flags;
      strobe(4'hF);
      {gen_gyro_strobe_i, gen_accel_strobe_i, stab_gyro_strobe_i, stab_accel_strobe_i} = 4'h0;
      fork
         host_p.xfer(0, 8'h2C, r);
         host_a.xfer(0, 8'h23, r2);
      join
      chk(r, ex(10, 0));
      chk(r2, ex(1, 1));
      chk({7'h0, gyro_data_available_o, accel_data_available_o}, 9'h001);
      host_p.xfer(0, 8'h29, r);
      chk({7'h0, gyro_data_available_o, accel_data_available_o}, 9'h001);
      host_a.xfer(0, 8'h2D, r);
      chk({7'h0, gyro_data_available_o, accel_data_available_o}, 9'h000);
   endtask
   task automatic t_status;
      logic [7:0] pos [4] = '{8'h08, 8'h10, 8'h20, 8'h80};
      for (int b = 0; b < 4; b++) begin
         events_i = event_t'(4'(1 << b));
         @(negedge clock_i);
         events_i = '0;
         host_a.xfer(0, 8'h35, r);
         chk(r, {1'b1, pos[b]});
         host_p.xfer(0, 8'h35, r);
         chk(r, {1'b1, pos[b]});
         host_p.xfer(0, 8'h35, r);
         chk(r, 9'h100);
      end
   endtask
   task automatic t_write;
      host_p.xfer(1, 8'h22, r);
      chk({8'h00, r[8]}, 9'h000);
      host_a.xfer(1, 8'h2D, r);
      host_p.xfer(1, 8'h35, r);
      host_p.xfer(0, 8'h22, r);
      chk(r, ex(0, 0));
      host_a.xfer(0, 8'h2D, r);
      chk(r, ex(11, 1));
      host_p.xfer(0, 8'h35, r);
      chk(r, 9'h100);
      host_p.xfer(0, 8'h40, r);
      chk(r, {1'b1, UNMAPPED_READ_VALUE});
   endtask
   // The gen gyro strobe fires alone, so gen accel words must hold; then the stab accel strobe sets only the accel flag.
   task automatic t_split;
      for (int k = 0; k < 6; k++) begin
         gen_sample_i.word[k] = w(k, 1);
      end
      strobe(4'h8);
      strobe(4'h0);
      host_p.xfer(0, 8'h23, r);
      chk(r, ex(1, 1));
      host_p.xfer(0, 8'h29, r);
      chk(r, ex(7, 0));
      strobe(4'h1);
      strobe(4'h0);
      chk({7'h0, gyro_data_available_o, accel_data_available_o}, 9'h001);
   endtask
   task automatic finish_test;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // The whole sequence takes about 113 cycles of the 800 allowed, so this limit only trips on a hang.
   initial begin
      #20000;
      errors++;
      finish_test();
   end
   initial begin
      repeat (4) @(negedge clock_i);
      resetn_i = 1;
      t_axes();
      t_flags();
      t_status();
      t_write();
      t_split();
      finish_test();
   end
endmodule
